// ==== hw/lsc_handler.sv ====
// Purpose: lifecycle state transit / request command interpreter on a byte stream
// Assumes: all inputs on ref_clk; flash and strap inputs stable after reset
// Notes:   two-entry reply buffer; one command in flight at a time
// Notes on behaviour
// - wait for header byte, drop others
// - source 04h/08h, destination 06h/09h codes
// - success reply frame with sum 8Dh
// - failure reply F1h with status, detail, address
// - missing end byte gives packet error
// - sum mismatch gives checksum error
// - bad lengths give packet error
// - any check error: no execution, wait again
// - command not allowed in state: acceptance error
// - encrypted write without reset: acceptance error
// - source differs from state: parameter error
// - only two transitions allowed, else parameter error
// - locked boot disabled: protection error
// - flash failure: flash error with status
// - bad readback: hardware error then silent
// - terminal state reached: reply then silent
// - other success: reply then wait again
// - report only highest priority error
// - state request answered with state byte
// - locked boot at init: software reset only
// - state codes 04h,06h,07h,08h,09h
`timescale 1ns/1ps
`include "lsc_cfg.svh"
module lsc_handler #(
  parameter int unsigned DW           = 8,
  parameter logic [7:0]  STS_PACKET   = 8'hC0,
  parameter logic [7:0]  STS_CHECKSUM = 8'hC1,
  parameter logic [7:0]  STS_ACCEPT   = 8'hC2,
  parameter logic [7:0]  STS_PARAM    = 8'hC3,
  parameter logic [7:0]  STS_PROTECT  = 8'hC4,
  parameter logic [7:0]  STS_FLASH    = 8'hC5,
  parameter logic [7:0]  STS_HW       = 8'hC6
) (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_valid,
  output logic               rx_ready,
  output logic [DW-1:0]      tx_data,
  output logic               tx_valid,
  input  wire logic          tx_ready,
  input  wire logic [7:0]    stored_state,
  input  wire logic          locked_boot_enable,
  input  wire logic          enc_write_done,
  output logic               flash_req,
  output logic [7:0]         flash_state,
  input  wire logic          flash_done,
  input  wire logic          flash_error,
  input  wire logic [31:0]   flash_status,
  input  wire logic [7:0]    readback_state,
  input  wire logic          readback_prot_ok,
  output logic               sw_reset_req
);
  import lsc_pkg::*;

  lsc_phase_t  phase_q, phase_d;
  logic [15:0] len_q, cnt_q;
  logic [7:0]  cmd_q, src_q, dst_q, sum_q, cur_state_q;
  logic        etx_bad_q, enc_lock_q, halt_after_q, kind_state_q;
  logic [7:0]  res_q, sts_q;
  logic [31:0] detail_q;
  logic [3:0]  rep_idx_q;
  logic [7:0]  rep_sum_q, rep_byte;
  logic [DW-1:0] ent0_q, ent1_q;
  logic        v0_q, v1_q, push, pop;
  logic        rx_ready_q, flash_req_q, sw_reset_q;
  logic        take, fmt_bad, len_bad, known, acc_bad, par_bad, prot_bad, sum_bad, chk_ok, hw_bad;
  logic [3:0]  rep_end;

  assign take         = rx_valid && rx_ready_q;
  assign rx_ready     = rx_ready_q;
  assign tx_data      = ent0_q;
  assign tx_valid     = v0_q;
  assign flash_req    = flash_req_q;
  assign flash_state  = dst_q;
  assign sw_reset_req = sw_reset_q;

  assign sum_bad  = (sum_q != 8'h00);
  assign fmt_bad  = (len_q == 16'h0000);
  assign len_bad  = (cmd_q == `LSC_CMD_TRANSIT && len_q != `LSC_LEN_TRANSIT) ||
                    (cmd_q == `LSC_CMD_REQUEST && len_q != `LSC_LEN_REQUEST);
  assign known    = (cmd_q == `LSC_CMD_TRANSIT) || (cmd_q == `LSC_CMD_REQUEST);
  assign acc_bad  = enc_lock_q || !known ||
                    (cmd_q == `LSC_CMD_TRANSIT && cur_state_q != `LSC_ST_MFR && cur_state_q != `LSC_ST_RET_ACK);
  assign par_bad  = (src_q != cur_state_q) ||
                    !((src_q == `LSC_ST_MFR && dst_q == `LSC_ST_LOCKED) ||
                      (src_q == `LSC_ST_RET_ACK && dst_q == `LSC_ST_RETURNED));
  assign prot_bad = (dst_q == `LSC_ST_LOCKED) && !locked_boot_enable;
  assign chk_ok   = !etx_bad_q && !sum_bad && !fmt_bad && !len_bad && !acc_bad &&
                    (cmd_q == `LSC_CMD_REQUEST || (!par_bad && !prot_bad));
  // readback must be a known code
  assign hw_bad   = !readback_prot_ok ||
                    !(readback_state == `LSC_ST_MFR || readback_state == `LSC_ST_LOCKED ||
                      readback_state == `LSC_ST_RET_REQ || readback_state == `LSC_ST_RET_ACK ||
                      readback_state == `LSC_ST_RETURNED);
  assign rep_end  = kind_state_q ? `LSC_IDX_STATE_END : `LSC_IDX_STATUS_END;

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      // locked boot never reaches command phase
      lsc_ph_init:     phase_d = (stored_state == `LSC_ST_LOCKED) ? lsc_ph_swreset : lsc_ph_wait_soh;
      lsc_ph_wait_soh: if (take && rx_data == `LSC_SOH) begin
        phase_d = lsc_ph_len_h;
      end
      lsc_ph_len_h:    if (take) begin
        phase_d = lsc_ph_len_l;
      end
      lsc_ph_len_l:    if (take) begin
        phase_d = ({len_q[15:8], rx_data} == 16'h0000) ? lsc_ph_sum : lsc_ph_body;
      end
      lsc_ph_body:     if (take && cnt_q == len_q - 16'h0001) begin
        phase_d = lsc_ph_sum;
      end
      lsc_ph_sum:      if (take) begin
        phase_d = lsc_ph_etx;
      end
      lsc_ph_etx:      if (take) begin
        phase_d = lsc_ph_check;
      end
      // any failed check goes straight to the error reply
      lsc_ph_check:    phase_d = (chk_ok && cmd_q == `LSC_CMD_TRANSIT) ? lsc_ph_flash : lsc_ph_reply;
      lsc_ph_flash:    if (flash_done) begin
        phase_d = flash_error ? lsc_ph_reply : lsc_ph_verify;
      end
      lsc_ph_verify:   phase_d = lsc_ph_reply;
      // silent or waiting after the reply
      lsc_ph_reply:    if (push && rep_idx_q == rep_end) begin
        phase_d = halt_after_q ? lsc_ph_halt : lsc_ph_wait_soh;
      end
      lsc_ph_halt:     phase_d = lsc_ph_halt;
      lsc_ph_swreset:  phase_d = lsc_ph_swreset;
      default:         phase_d = lsc_ph_halt;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q    <= lsc_ph_init;
      rx_ready_q <= 1'b0;
      flash_req_q <= 1'b0;
      sw_reset_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      rx_ready_q <= (phase_d inside {lsc_ph_wait_soh, lsc_ph_len_h, lsc_ph_len_l, lsc_ph_body,
                                     lsc_ph_sum, lsc_ph_etx});
      flash_req_q <= (phase_d == lsc_ph_flash);
      sw_reset_q <= (phase_d == lsc_ph_swreset);
    end
  end

  // frame capture and running sum
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      len_q     <= 16'h0000;
      cnt_q     <= 16'h0000;
      cmd_q     <= 8'h00;
      src_q     <= 8'h00;
      dst_q     <= 8'h00;
      sum_q     <= 8'h00;
      etx_bad_q <= 1'b0;
    end else if (take) begin
      unique case (phase_q)
        lsc_ph_wait_soh: begin
          sum_q <= 8'h00;
          cnt_q <= 16'h0000;
          cmd_q <= 8'h00;
        end
        lsc_ph_len_h: begin
          len_q[15:8] <= rx_data;
          sum_q       <= sum_q + rx_data;
        end
        lsc_ph_len_l: begin
          len_q[7:0] <= rx_data;
          sum_q      <= sum_q + rx_data;
        end
        lsc_ph_body: begin
          if (cnt_q == 16'h0000) begin
            cmd_q <= rx_data;
          end
          if (cnt_q == 16'h0001) begin
            src_q <= rx_data;
          end
          if (cnt_q == 16'h0002) begin
            dst_q <= rx_data;
          end
          cnt_q <= cnt_q + 16'h0001;
          sum_q <= sum_q + rx_data;
        end
        // sum byte closes the total to zero
        lsc_ph_sum: sum_q <= sum_q + rx_data;
        lsc_ph_etx: etx_bad_q <= (rx_data != `LSC_ETX);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_lock_q <= 1'b0;
    end else if (enc_write_done) begin
      enc_lock_q <= 1'b1;
    end
  end

  // strap taken in the first clocked cycle after release, not under reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_state_q <= 8'h00;
    end else if (phase_q == lsc_ph_init) begin
      cur_state_q <= stored_state;
    end else if (phase_q == lsc_ph_verify && !hw_bad) begin
      cur_state_q <= readback_state;
    end
  end

  // reply fields, one outcome per command
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_q        <= 8'h00;
      sts_q        <= `LSC_STS_OK;
      detail_q     <= `LSC_UNUSED_WORD;
      halt_after_q <= 1'b0;
      kind_state_q <= 1'b0;
    end else if (phase_q == lsc_ph_check) begin
      detail_q     <= `LSC_UNUSED_WORD;
      halt_after_q <= 1'b0;
      kind_state_q <= chk_ok && cmd_q == `LSC_CMD_REQUEST;
      res_q        <= (cmd_q == `LSC_CMD_TRANSIT) ? `LSC_RES_TRANSIT_NG :
                      (cmd_q == `LSC_CMD_REQUEST) ? `LSC_RES_REQUEST_NG : (cmd_q | `LSC_RES_NG_FLAG);
      if (etx_bad_q) begin
        sts_q <= STS_PACKET;
      end else if (sum_bad) begin
        sts_q <= STS_CHECKSUM;
      end else if (fmt_bad || len_bad) begin
        sts_q <= STS_PACKET;
      end else if (acc_bad) begin
        sts_q <= STS_ACCEPT;
      end else if (cmd_q == `LSC_CMD_REQUEST) begin
        res_q <= `LSC_CMD_REQUEST;
        sts_q <= `LSC_STS_OK;
      end else if (par_bad) begin
        sts_q <= STS_PARAM;
      end else if (prot_bad) begin
        sts_q <= STS_PROTECT;
      end else begin
        sts_q <= `LSC_STS_OK;
      end
    end else if (phase_q == lsc_ph_flash && flash_done && flash_error) begin
      // flash status carried in the detail field
      sts_q    <= STS_FLASH;
      detail_q <= flash_status;
    end else if (phase_q == lsc_ph_verify) begin
      if (hw_bad) begin
        sts_q        <= STS_HW;
        halt_after_q <= 1'b1;
      end else begin
        res_q        <= `LSC_CMD_TRANSIT;
        sts_q        <= `LSC_STS_OK;
        halt_after_q <= (readback_state == `LSC_ST_LOCKED) || (readback_state == `LSC_ST_RETURNED);
      end
    end
  end

  always_comb begin
    rep_byte = `LSC_ETX;
    if (kind_state_q) begin
      unique case (rep_idx_q)
        4'h0:    rep_byte = `LSC_SOD;
        4'h1:    rep_byte = 8'h00;
        4'h2:    rep_byte = `LSC_LEN_STATE;
        4'h3:    rep_byte = `LSC_CMD_REQUEST;
        4'h4:    rep_byte = cur_state_q;
        4'h5:    rep_byte = 8'h00 - rep_sum_q;
        default: rep_byte = `LSC_ETX;
      endcase
    end else begin
      unique case (rep_idx_q)
        4'h0:    rep_byte = `LSC_SOD;
        4'h1:    rep_byte = 8'h00;
        4'h2:    rep_byte = `LSC_LEN_STATUS;
        4'h3:    rep_byte = res_q;
        4'h4:    rep_byte = sts_q;
        4'h5:    rep_byte = detail_q[31:24];
        4'h6:    rep_byte = detail_q[23:16];
        4'h7:    rep_byte = detail_q[15:8];
        4'h8:    rep_byte = detail_q[7:0];
        4'h9:    rep_byte = 8'hFF;
        4'hA:    rep_byte = 8'hFF;
        4'hB:    rep_byte = 8'hFF;
        4'hC:    rep_byte = 8'hFF;
        4'hD:    rep_byte = 8'h00 - rep_sum_q;
        default: rep_byte = `LSC_ETX;
      endcase
    end
  end

  // generator stalls on a full buffer, so a slow receiver loses nothing
  assign push = (phase_q == lsc_ph_reply) && !v1_q;
  assign pop  = v0_q && tx_ready;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rep_idx_q <= 4'h0;
      rep_sum_q <= 8'h00;
    end else if (phase_q != lsc_ph_reply) begin
      rep_idx_q <= 4'h0;
      rep_sum_q <= 8'h00;
    end else if (push) begin
      rep_idx_q <= rep_idx_q + 4'h1;
      if (rep_idx_q != 4'h0) begin
        rep_sum_q <= rep_sum_q + rep_byte;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ent0_q <= '0;
      ent1_q <= '0;
      v0_q   <= 1'b0;
      v1_q   <= 1'b0;
    end else if (push && pop) begin
      if (v1_q) begin
        ent0_q <= ent1_q;
        ent1_q <= DW'(rep_byte);
      end else begin
        ent0_q <= DW'(rep_byte);
      end
    end else if (push) begin
      if (v0_q) begin
        ent1_q <= DW'(rep_byte);
        v1_q   <= 1'b1;
      end else begin
        ent0_q <= DW'(rep_byte);
        v0_q   <= 1'b1;
      end
    end else if (pop) begin
      ent0_q <= ent1_q;
      v0_q   <= v1_q;
      v1_q   <= 1'b0;
    end
  end

  // checking helpers
  logic [7:0] chk_sum_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_sum_q <= 8'h00;
    end else if (push) begin
      chk_sum_q <= (rep_idx_q == 4'h0) ? 8'h00 : chk_sum_q + rep_byte;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_halt_silent: assert property (phase_q == lsc_ph_halt |-> !rx_ready_q && !flash_req_q)
    else $error("input taken while halted");
  chk_locked_init: assert property (phase_q == lsc_ph_init && stored_state == `LSC_ST_LOCKED |=> ##1 sw_reset_q && !rx_ready_q)
    else $error("locked boot did not request software reset");
  chk_flash_gate: assert property ($rose(flash_req_q) |-> $past(phase_q) == lsc_ph_check && $past(chk_ok))
    else $error("flash write after a failed check");
  chk_reply_head: assert property (push && rep_idx_q == 4'h0 |-> rep_byte == `LSC_SOD)
    else $error("reply does not open with start of data");
  chk_reply_sum: assert property (push && rep_idx_q == rep_end |-> chk_sum_q == 8'h00 && rep_byte == `LSC_ETX)
    else $error("reply sum does not close to zero");
  chk_enc_lock: assert property (phase_q == lsc_ph_check && enc_lock_q && !etx_bad_q && !sum_bad && !fmt_bad && !len_bad
                                 |=> sts_q == STS_ACCEPT)
    else $error("command taken after encrypted write");
  chk_etx_first: assert property (phase_q == lsc_ph_check && etx_bad_q |=> sts_q == STS_PACKET && !flash_req_q)
    else $error("missing end byte not reported first");
  chk_sum_next: assert property (phase_q == lsc_ph_check && !etx_bad_q && sum_bad |=> sts_q == STS_CHECKSUM)
    else $error("checksum error not reported");
  chk_hw_halt: assert property (phase_q == lsc_ph_verify && hw_bad |=> sts_q == STS_HW && halt_after_q)
    else $error("bad readback not reported as hardware error");
  chk_tx_hold: assert property (v0_q && !tx_ready |=> v0_q && $stable(ent0_q))
    else $error("reply byte dropped under stall");

  cov_transit_ok: cover property (phase_q == lsc_ph_verify && !hw_bad);
  cov_state_reply: cover property (push && kind_state_q && rep_idx_q == `LSC_IDX_STATE_END);
  cov_buffer_full: cover property (v1_q && !tx_ready);
  cov_flash_fail: cover property (phase_q == lsc_ph_flash && flash_done && flash_error);
endmodule : lsc_handler

// ==== hw/lsc_cfg.svh ====
// Purpose: framing bytes, codes and lengths of the lifecycle state command handler
// Assumes: byte stream, one clock
// Notes:   definitions only
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH
`define LSC_SOH            8'h01
`define LSC_ETX            8'h03
`define LSC_SOD            8'h81
`define LSC_CMD_TRANSIT    8'h71
`define LSC_CMD_REQUEST    8'h2C
`define LSC_RES_TRANSIT_NG 8'hF1
`define LSC_RES_REQUEST_NG 8'hAC
`define LSC_RES_NG_FLAG    8'h80
`define LSC_STS_OK         8'h00
`define LSC_LEN_TRANSIT    16'h0003
`define LSC_LEN_REQUEST    16'h0001
`define LSC_LEN_STATUS     8'h0A
`define LSC_LEN_STATE      8'h02
`define LSC_UNUSED_WORD    32'hFFFFFFFF
`define LSC_ST_MFR         8'h04
`define LSC_ST_LOCKED      8'h06
`define LSC_ST_RET_REQ     8'h07
`define LSC_ST_RET_ACK     8'h08
`define LSC_ST_RETURNED    8'h09
`define LSC_IDX_STATUS_SUM 4'hD
`define LSC_IDX_STATUS_END 4'hE
`define LSC_IDX_STATE_SUM  4'h5
`define LSC_IDX_STATE_END  4'h6
`endif

// ==== hw/lsc_pkg.sv ====
// Purpose: types of the lifecycle state command handler
// Assumes: nothing
// Notes:   phase codes written out
package lsc_pkg;
  typedef enum logic [3:0] {
    lsc_ph_init     = 4'h0,
    lsc_ph_wait_soh = 4'h1,
    lsc_ph_len_h    = 4'h2,
    lsc_ph_len_l    = 4'h3,
    lsc_ph_body     = 4'h4,
    lsc_ph_sum      = 4'h5,
    lsc_ph_etx      = 4'h6,
    lsc_ph_check    = 4'h7,
    lsc_ph_flash    = 4'h8,
    lsc_ph_verify   = 4'h9,
    lsc_ph_reply    = 4'hA,
    lsc_ph_halt     = 4'hB,
    lsc_ph_swreset  = 4'hC
  } lsc_phase_t;
endpackage : lsc_pkg

// ==== testbench/lsc_host_model.sv ====
// Purpose: host programmer model facing lsc_handler
// Assumes: one byte per valid/ready handshake on ref_clk
// Notes:   slow makes tx_ready toggle so replies back up in the buffer
`timescale 1ns/1ps
module lsc_host_model (
  input  wire logic       ref_clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] out_q[$];
  logic [7:0] in_q[$];
  logic       slow;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end
  // bytes leave in order, held until taken
  always @(posedge ref_clk) begin
    if (rx_valid && rx_ready) begin
      out_q.delete(0);
    end
    rx_valid <= (out_q.size() > 0);
    // idle line toggles so a stale byte never looks valid
    rx_data  <= (out_q.size() > 0) ? out_q[0] : ~rx_data;
  end
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      in_q.push_back(tx_data);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : lsc_host_model

// ==== testbench/tb_lsc_handler.sv ====
// Purpose: self-checking bench of lsc_handler
// Assumes: host model and flash responder of this bench
// Notes:   each row starts from a reset with its own stored state
`timescale 1ns/1ps
module tb_lsc_handler;
  typedef struct packed {
    logic [7:0] st;
    logic       lbe;
    logic       fe;
    logic [7:0] rb;
    logic [7:0] cmd;
    logic [7:0] src;
    logic [7:0] dst;
    logic [3:0] bad;
    logic [7:0] res;
    logic [7:0] sts;
    logic [7:0] after;
  } lsc_row_t;
  localparam int NR = 20;
  localparam logic [31:0] FST = 32'h00005A3C;
  lsc_row_t rows [NR] = '{
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h0,8'h71,8'h00,8'h00},
    '{8'h08,1'b1,1'b0,8'h09,8'h71,8'h08,8'h09,4'h0,8'h71,8'h00,8'h00},
    '{8'h04,1'b1,1'b0,8'h00,8'h2C,8'h00,8'h00,4'h0,8'h2C,8'h04,8'h04},
    '{8'h07,1'b1,1'b0,8'h00,8'h2C,8'h00,8'h00,4'h0,8'h2C,8'h07,8'h07},
    '{8'h08,1'b1,1'b0,8'h00,8'h2C,8'h00,8'h00,4'h0,8'h2C,8'h08,8'h08},
    '{8'h09,1'b1,1'b0,8'h00,8'h2C,8'h00,8'h00,4'h0,8'h2C,8'h09,8'h09},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h08,8'h06,4'h0,8'hF1,8'hC3,8'h04},
    '{8'h04,1'b1,1'b0,8'h09,8'h71,8'h04,8'h09,4'h0,8'hF1,8'hC3,8'h04},
    '{8'h08,1'b1,1'b0,8'h06,8'h71,8'h08,8'h06,4'h0,8'hF1,8'hC3,8'h08},
    '{8'h07,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h0,8'hF1,8'hC2,8'h07},
    '{8'h04,1'b0,1'b0,8'h06,8'h71,8'h04,8'h06,4'h0,8'hF1,8'hC4,8'h04},
    '{8'h04,1'b1,1'b1,8'h06,8'h71,8'h04,8'h06,4'h0,8'hF1,8'hC5,8'h04},
    '{8'h08,1'b1,1'b0,8'h05,8'h71,8'h08,8'h09,4'h0,8'hF1,8'hC6,8'h00},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h1,8'hF1,8'hC0,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h2,8'hF1,8'hC1,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h4,8'hF1,8'hC0,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h3,8'hF1,8'hC0,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h6,8'hF1,8'hC1,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h55,8'h04,8'h06,4'h0,8'hD5,8'hC2,8'h04},
    '{8'h04,1'b1,1'b0,8'h06,8'h71,8'h04,8'h06,4'h8,8'h80,8'hC0,8'h04}};
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, flash_req, flash_done, sw_reset_req;
  logic [7:0]  rx_data, tx_data, flash_state;
  logic [7:0]  stored_state, readback_state;
  logic [7:0]  fl_exp = 8'h00;
  logic        locked_boot_enable, flash_error;
  logic        enc_write_done = 1'b0;
  logic [31:0] flash_status = FST;
  logic        readback_prot_ok = 1'b1;
  logic [3:0]  fl_cnt = 4'h0;
  int          fails = 0;
  int          comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  lsc_handler dut (.ref_clk(ref_clk), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .stored_state(stored_state), .locked_boot_enable(locked_boot_enable),
    .enc_write_done(enc_write_done), .flash_req(flash_req), .flash_state(flash_state),
    .flash_done(flash_done), .flash_error(flash_error), .flash_status(flash_status),
    .readback_state(readback_state), .readback_prot_ok(readback_prot_ok), .sw_reset_req(sw_reset_req));
  lsc_host_model host (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  // flash store takes a few cycles, then one done pulse
  always @(posedge ref_clk) begin
    fl_cnt     <= (flash_req && !flash_done) ? fl_cnt + 4'h1 : 4'h0;
    flash_done <= flash_req && (fl_cnt == 4'h3);
    if (flash_req && fl_cnt == 4'h0) check(flash_state, fl_exp);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic restart(input logic [7:0] st);
    reset_n      <= 1'b0;
    stored_state <= st;
    host.out_q.delete();
    host.in_q.delete();
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : restart
  task automatic send(input logic [7:0] cmd, src, dst, input logic [3:0] bad);
    logic [7:0] b[$];
    logic [7:0] s;
    // codes in place, sum closes to zero
    if (bad[3]) b = '{8'h00, 8'h00};
    else if (cmd == 8'h2C || bad[2]) b = '{8'h00, 8'h01, cmd};
    else b = '{8'h00, 8'h03, cmd, src, dst};
    s = 8'h00;
    foreach (b[i]) s -= b[i];
    b.push_back(bad[1] ? s + 8'h01 : s);
    b.push_back(bad[0] ? 8'h04 : 8'h03);
    host.out_q.push_back(8'h01);
    foreach (b[i]) host.out_q.push_back(b[i]);
  endtask : send
  task automatic expect_reply(input logic [7:0] res, sts, input logic [31:0] det);
    logic [7:0] e[$];
    logic [7:0] s;
    int         n;
    if (res == 8'h2C) e = '{8'h00, 8'h02, res, sts};
    else e = '{8'h00, 8'h0A, res, sts, det[31:24], det[23:16], det[15:8], det[7:0],
               8'hFF, 8'hFF, 8'hFF, 8'hFF};
    s = 8'h00;
    foreach (e[i]) s -= e[i];
    e.push_back(s);
    e.push_back(8'h03);
    e.push_front(8'h81);
    n = 0;
    while (host.in_q.size() < e.size() && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    check(host.in_q.size() >= e.size(), 1'b1);
    foreach (e[i]) if (i < host.in_q.size()) check(host.in_q[i], e[i]);
    foreach (e[i]) if (host.in_q.size() > 0) host.in_q.delete(0);
  endtask : expect_reply
  task automatic expect_silent;
    repeat (80) @(posedge ref_clk);
    check(host.in_q.size(), 0);
  endtask : expect_silent
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #1ms;
    fails++;
    report_and_stop();
  end
  initial begin
    lsc_row_t r;
    foreach (rows[k]) begin
      r = rows[k];
      fl_exp = r.dst;
      locked_boot_enable <= r.lbe;
      flash_error        <= r.fe;
      readback_state     <= r.rb;
      restart(r.st);
      send(r.cmd, r.src, r.dst, r.bad);
      expect_reply(r.res, r.sts, (r.sts == 8'hC5) ? FST : 32'hFFFFFFFF);
      send(8'h2C, 8'h00, 8'h00, 4'h0);
      if (r.after == 8'h00) expect_silent();
      else expect_reply(8'h2C, r.after, 32'h0);
    end
    // stray bytes before the header, two frames back to back, slow receiver
    locked_boot_enable <= 1'b1;
    restart(8'h08);
    host.slow = 1'b1;
    host.out_q.push_back(8'h55);
    host.out_q.push_back(8'h03);
    send(8'h2C, 8'h00, 8'h00, 4'h0);
    send(8'h2C, 8'h00, 8'h00, 4'h0);
    expect_reply(8'h2C, 8'h08, 32'h0);
    expect_reply(8'h2C, 8'h08, 32'h0);
    host.slow = 1'b0;
    // encrypted write leaves a lock that only reset clears
    enc_write_done <= 1'b1;
    @(posedge ref_clk);
    enc_write_done <= 1'b0;
    send(8'h2C, 8'h00, 8'h00, 4'h0);
    expect_reply(8'hAC, 8'hC2, 32'hFFFFFFFF);
    send(8'h71, 8'h08, 8'h09, 4'h0);
    expect_reply(8'hF1, 8'hC2, 32'hFFFFFFFF);
    // valid state but bad protection level read back
    readback_prot_ok <= 1'b0;
    readback_state   <= 8'h09;
    fl_exp = 8'h09;
    restart(8'h08);
    send(8'h71, 8'h08, 8'h09, 4'h0);
    expect_reply(8'hF1, 8'hC6, 32'hFFFFFFFF);
    send(8'h2C, 8'h00, 8'h00, 4'h0);
    expect_silent();
    readback_prot_ok <= 1'b1;
    restart(8'h06);
    check(sw_reset_req, 1'b1);
    send(8'h2C, 8'h00, 8'h00, 4'h0);
    expect_silent();
    check(rx_ready, 1'b0);
    report_and_stop();
  end
endmodule : tb_lsc_handler
